// ### rtl/urx_params.svh
// constants of the asynchronous receiver: offsets, field positions, reset values, counts
`ifndef URX_PARAMS_SVH
`define URX_PARAMS_SVH

// register offsets
`define URX_OFS_RCV_CTRL     2'h0
`define URX_OFS_RCV_DATA     2'h1
`define URX_OFS_IRQ_MODE     2'h2
`define URX_OFS_PIN_CTRL     2'h3

// receive_control_status fields
`define URX_BIT_SERIAL_PORT_ENABLE         7
`define URX_BIT_RX9          6
`define URX_BIT_CONTINUOUS_RECEIVE_ENABLE         4
`define URX_BIT_ADDRESS_DETECT_ENABLE        3
`define URX_BIT_FRAMING_ERROR_FLAG         2
`define URX_BIT_OVERRUN_ERROR_FLAG         1
`define URX_BIT_RECEIVED_NINTH_BIT         0

// irq / mode register fields
`define URX_BIT_SYNC         0
`define URX_BIT_RECEIVE_IRQ_ENABLE         3
`define URX_BIT_PERIPHERAL_IRQ_ENABLE         4
`define URX_BIT_GIE          5
`define URX_BIT_PEND         7

// pin control register fields
`define URX_BIT_TX_LATCH     0
`define URX_BIT_RX_LATCH     1
`define URX_BIT_TX_DIR       2
`define URX_BIT_RX_DIR       3

// reset values
`define URX_RST_CTRL         1'b0
`define URX_RST_PIN_CTRL     4'hc

// oversampling: ticks per bit and positions inside a bit; bits per character and fifo depth
`define URX_OVERSAMPLE       5'h10
`define URX_HALF_BIT         4'h7
`define URX_VOTE_FIRST       4'hd
`define URX_BIT_CENTRE       4'hf
`define URX_BITS_SHORT       4'h8
`define URX_BITS_LONG        4'h9
`define URX_FIFO_DEPTH       2'h2

`endif

// ### rtl/urx_pkg.sv
// types of the asynchronous receiver
`default_nettype none
package urx_pkg;

  typedef enum logic [1:0] {
    URX_IDLE  = 2'b00,
    URX_START = 2'b01,
    URX_DATA  = 2'b10,
    URX_STOP  = 2'b11
  } urx_state_t;

  // one fifo entry: framing error, ninth bit, low eight bits
  typedef struct packed {
    logic       framing_error_flag;
    logic [8:0] data;
  } urx_entry_t;

  typedef struct packed {
    logic                 serial_port_enable;
    logic                 rx9;
    logic                 continuous_receive_enable;
    logic                 address_detect_enable;
    logic                 sync;
    logic                 receive_irq_enable;
    logic                 peripheral_irq_enable;
    logic                 global_irq_enable;
    logic [3:0]           pins;
    logic                 rx_meta;
    logic                 rx_sync;
    logic                 rx_prev;
    urx_state_t           st;
    logic [3:0]           tick_cnt;
    logic [3:0]           bit_cnt;
    logic [1:0]           votes;
    logic [8:0]           shreg;
    urx_entry_t [1:0]     fifo;
    logic                 head;
    logic [1:0]           count;
    logic                 overrun_error_flag;
    logic [7:0]           rdata;
  } urx_regs_t;

endpackage

`default_nettype wire

// ### rtl/urx_receiver.sv
// asynchronous serial receiver with two-deep fifo and register port
// Contract
// - sample line at sixteen times bit rate
// - completed character goes into two-deep fifo
// - receive only when enabled, async, port on
// - port enable forces pin directions
// - false start bit dropped silently
// - majority vote at each bit centre
// - low stop level marks framing error
// - push and pending flag at stop bit centre
// - data read pops oldest character
// - pending flag means enabled and unread
// - irq needs flag and three enables
// - framing error stored per entry
// - framing error is passive read-only status
// - port disable resets receiver and errors
// - third character sets overrun, locks reception
// - overrun cleared only by disabling
// - nine-bit mode exposes ninth bit
// - address detect in nine-bit mode keeps ninth-bit characters only
// - least significant bit arrives first
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "urx_params.svh"

module urx_receiver
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       baud_tick16,
  input  wire logic       rx_pin_in,
  output logic            rx_pin_out,
  output logic            rx_pin_oe_n,
  input  wire logic       tx_serial_data,
  output logic            tx_pin_out,
  output logic            tx_pin_oe_n,
  output logic            receive_pending_flag,
  output logic            rx_irq
);

  urx_pkg::urx_regs_t state_ff;
  urx_pkg::urx_regs_t nxt_state;

  logic             rx_active;
  logic             pop;
  logic             push;
  logic             full;
  logic             vote;
  logic             tail;
  logic [3:0]       last_bit;
  urx_pkg::urx_entry_t new_entry;
  urx_pkg::urx_entry_t top_entry;

  // majority of three samples
  function automatic logic majority(input logic [1:0] prior, input logic now);
    majority = (prior[0] & prior[1]) | (prior[0] & now) | (prior[1] & now);
  endfunction

  assign rx_active = state_ff.serial_port_enable & state_ff.continuous_receive_enable & ~state_ff.sync;
  assign top_entry = state_ff.fifo[state_ff.head];
  assign last_bit  = state_ff.rx9 ? `URX_BITS_LONG - 4'h1
                                  : `URX_BITS_SHORT - 4'h1;

  always_comb
  begin
    nxt_state = state_ff;
    push      = 1'b0;
    full      = 1'b0;
    vote      = 1'b0;
    tail      = 1'b0;
    new_entry = '0;

    // two-flop synchroniser, third flop for edge search
    nxt_state.rx_meta = rx_pin_in;
    nxt_state.rx_sync = state_ff.rx_meta;
    nxt_state.rx_prev = state_ff.rx_sync;

    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        `URX_OFS_RCV_CTRL:
        begin
          nxt_state.serial_port_enable  = reg_wdata[`URX_BIT_SERIAL_PORT_ENABLE];
          nxt_state.rx9   = reg_wdata[`URX_BIT_RX9];
          nxt_state.continuous_receive_enable  = reg_wdata[`URX_BIT_CONTINUOUS_RECEIVE_ENABLE];
          nxt_state.address_detect_enable = reg_wdata[`URX_BIT_ADDRESS_DETECT_ENABLE];
        end
        `URX_OFS_IRQ_MODE:
        begin
          nxt_state.sync = reg_wdata[`URX_BIT_SYNC];
          nxt_state.receive_irq_enable = reg_wdata[`URX_BIT_RECEIVE_IRQ_ENABLE];
          nxt_state.peripheral_irq_enable = reg_wdata[`URX_BIT_PERIPHERAL_IRQ_ENABLE];
          nxt_state.global_irq_enable  = reg_wdata[`URX_BIT_GIE];
        end
        `URX_OFS_PIN_CTRL:
        begin
          nxt_state.pins = reg_wdata[3:0];
        end
        default:
        begin
          nxt_state.pins = state_ff.pins;
        end
      endcase
    end

    // register reads, answered one cycle later
    nxt_state.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `URX_OFS_RCV_CTRL:
        begin
          nxt_state.rdata[`URX_BIT_SERIAL_PORT_ENABLE]  = state_ff.serial_port_enable;
          nxt_state.rdata[`URX_BIT_RX9]   = state_ff.rx9;
          nxt_state.rdata[`URX_BIT_CONTINUOUS_RECEIVE_ENABLE]  = state_ff.continuous_receive_enable;
          nxt_state.rdata[`URX_BIT_ADDRESS_DETECT_ENABLE] = state_ff.address_detect_enable;
          nxt_state.rdata[`URX_BIT_FRAMING_ERROR_FLAG]  = top_entry.framing_error_flag;
          nxt_state.rdata[`URX_BIT_OVERRUN_ERROR_FLAG]  = state_ff.overrun_error_flag;
          nxt_state.rdata[`URX_BIT_RECEIVED_NINTH_BIT]  = top_entry.data[8];
        end
        `URX_OFS_RCV_DATA:
        begin
          nxt_state.rdata = top_entry.data[7:0];
        end
        `URX_OFS_IRQ_MODE:
        begin
          nxt_state.rdata[`URX_BIT_SYNC] = state_ff.sync;
          nxt_state.rdata[`URX_BIT_RECEIVE_IRQ_ENABLE] = state_ff.receive_irq_enable;
          nxt_state.rdata[`URX_BIT_PERIPHERAL_IRQ_ENABLE] = state_ff.peripheral_irq_enable;
          nxt_state.rdata[`URX_BIT_GIE]  = state_ff.global_irq_enable;
          nxt_state.rdata[`URX_BIT_PEND] = receive_pending_flag;
        end
        default:
        begin
          nxt_state.rdata[3:0] = state_ff.pins;
        end
      endcase
    end

    // data recovery, advanced by the oversampling tick
    if (rx_active && baud_tick16)
    begin
      case (state_ff.st)
        urx_pkg::URX_IDLE:
        begin
          nxt_state.tick_cnt = 4'h0;
        end
        urx_pkg::URX_START:
        begin
          nxt_state.tick_cnt = state_ff.tick_cnt + 4'h1;
          if (state_ff.tick_cnt == `URX_HALF_BIT)
          begin
            nxt_state.tick_cnt = 4'h0;
            nxt_state.bit_cnt  = 4'h0;
            // line back high at mid start: give up, no error
            nxt_state.st = state_ff.rx_sync ? urx_pkg::URX_IDLE
                                            : urx_pkg::URX_DATA;
          end
        end
        urx_pkg::URX_DATA,
        urx_pkg::URX_STOP:
        begin
          nxt_state.tick_cnt = state_ff.tick_cnt + 4'h1;
          if (state_ff.tick_cnt >= `URX_VOTE_FIRST)
          begin
            nxt_state.votes = {state_ff.votes[0], state_ff.rx_sync};
          end
          if (state_ff.tick_cnt == `URX_BIT_CENTRE)
          begin
            vote = majority(state_ff.votes, state_ff.rx_sync);
            if (state_ff.st == urx_pkg::URX_DATA)
            begin
              // lsb first, each bit lands at its own index
              nxt_state.shreg[state_ff.bit_cnt] = vote;
              nxt_state.bit_cnt = state_ff.bit_cnt + 4'h1;
              if (state_ff.bit_cnt == last_bit)
              begin
                nxt_state.st = urx_pkg::URX_STOP;
              end
            end
            else
            begin
              nxt_state.st   = urx_pkg::URX_IDLE;
              new_entry.framing_error_flag = ~vote;
              new_entry.data = {state_ff.rx9 & state_ff.shreg[8],
                                state_ff.shreg[7:0]};
              // locked while overrun stands
              push = ~state_ff.overrun_error_flag;
              if (state_ff.rx9 && state_ff.address_detect_enable && !state_ff.shreg[8])
              begin
                push = 1'b0;
              end
            end
          end
        end
        default:
        begin
          nxt_state.st = urx_pkg::URX_IDLE;
        end
      endcase
    end

    // falling edge search needs no tick
    if (rx_active && state_ff.st == urx_pkg::URX_IDLE &&
        state_ff.rx_prev && !state_ff.rx_sync)
    begin
      nxt_state.st       = urx_pkg::URX_START;
      nxt_state.tick_cnt = 4'h0;
      nxt_state.shreg    = 9'h000;
    end

    // fifo: pop on data read, push at centre of stop bit
    pop  = reg_rd && reg_addr == `URX_OFS_RCV_DATA
           && state_ff.count != 2'h0;
    full = state_ff.count == `URX_FIFO_DEPTH && !pop;
    if (push && full)
    begin
      push = 1'b0;
      nxt_state.overrun_error_flag = 1'b1;
    end
    tail = state_ff.head ^ state_ff.count[0];
    if (push)
    begin
      nxt_state.fifo[tail] = new_entry;
    end
    if (pop)
    begin
      nxt_state.head = ~state_ff.head;
    end
    nxt_state.count = state_ff.count + {1'b0, push} - {1'b0, pop};

    // receiver disabled: stop and drop overrun, fifo kept
    if (!state_ff.continuous_receive_enable)
    begin
      nxt_state.st   = urx_pkg::URX_IDLE;
      nxt_state.overrun_error_flag = 1'b0;
    end

    // port disabled: receiver idle, fifo and overrun cleared, control bits kept
    if (!state_ff.serial_port_enable)
    begin
      nxt_state.st    = urx_pkg::URX_IDLE;
      nxt_state.overrun_error_flag  = 1'b0;
      nxt_state.count = 2'h0;
      nxt_state.head  = 1'b0;
      nxt_state.fifo  = '0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff       <= '0;
      state_ff.serial_port_enable  <= `URX_RST_CTRL;
      state_ff.continuous_receive_enable  <= `URX_RST_CTRL;
      state_ff.pins  <= `URX_RST_PIN_CTRL;
      state_ff.rx_meta <= 1'b1;
      state_ff.rx_sync <= 1'b1;
      state_ff.rx_prev <= 1'b1;
      state_ff.st    <= urx_pkg::URX_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = state_ff.rdata;

  // pending flag only follows enable and fill, never software
  assign receive_pending_flag = rx_active && state_ff.count != 2'h0;

  // framing errors alone never reach the irq
  assign rx_irq = receive_pending_flag & state_ff.receive_irq_enable &
                  state_ff.peripheral_irq_enable & state_ff.global_irq_enable;

  // port enable overrides both pin directions and the tx latch
  assign rx_pin_oe_n = state_ff.serial_port_enable ? 1'b1 : state_ff.pins[`URX_BIT_RX_DIR];
  assign rx_pin_out  = state_ff.pins[`URX_BIT_RX_LATCH];
  assign tx_pin_oe_n = state_ff.serial_port_enable ? 1'b0 : state_ff.pins[`URX_BIT_TX_DIR];
  assign tx_pin_out  = state_ff.serial_port_enable ? tx_serial_data
                                     : state_ff.pins[`URX_BIT_TX_LATCH];

endmodule

`default_nettype wire

// ### bench/urx_receiver_checker.sv
// port assertions of the asynchronous receiver
`timescale 1ns/10ps
`default_nettype none
module urx_receiver_checker
(
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       baud_tick16,
  input wire logic       tx_serial_data,
  input wire logic       tx_pin_out,
  input wire logic       tx_pin_oe_n,
  input wire logic       rx_pin_oe_n,
  input wire logic       receive_pending_flag,
  input wire logic       rx_irq
);
  logic       serial_port_enable_q;
  logic       continuous_receive_enable_q;
  logic       sync_q;
  logic [2:0] ien_q;
  logic       en_q;
  // shadow of the enable bits, as written over the register port
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      serial_port_enable_q <= 1'b0;
      continuous_receive_enable_q <= 1'b0;
      sync_q <= 1'b0;
      ien_q  <= 3'h0;
    end
    else if (reg_wr && reg_addr == 2'h0)
    begin
      serial_port_enable_q <= reg_wdata[7];
      continuous_receive_enable_q <= reg_wdata[4];
    end
    else if (reg_wr && reg_addr == 2'h2)
    begin
      sync_q <= reg_wdata[0];
      ien_q  <= reg_wdata[5:3];
    end
  end
  assign en_q = serial_port_enable_q && continuous_receive_enable_q && !sync_q;
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence s_ctrl_rd;
    reg_rd && reg_addr == 2'h0;
  endsequence
  sequence s_mode_rd;
    reg_rd && reg_addr == 2'h2;
  endsequence
  AST_PIN_FORCE:
    assert property (serial_port_enable_q && $past(serial_port_enable_q) |->
      !tx_pin_oe_n && rx_pin_oe_n && tx_pin_out == tx_serial_data)
    else $error("pin directions not forced by port enable");
  AST_IRQ_AND:
    assert property (rx_irq == (receive_pending_flag && (&ien_q)))
    else $error("irq differs from flag and enables");
  AST_PEND_GATE:
    assert property (!en_q |-> !receive_pending_flag)
    else $error("pending flag while receiver off");
  AST_PEND_HOLD:
    assert property (receive_pending_flag && en_q && !(reg_rd && reg_addr == 2'h1) |=>
      receive_pending_flag || !en_q)
    else $error("pending flag dropped without a data read");
  AST_PEND_TICK:
    assert property ($rose(receive_pending_flag) && $past(en_q) |-> $past(baud_tick16))
    else $error("character pushed off a sampling tick");
  AST_CTRL_RB:
    assert property (s_ctrl_rd |=> reg_rdata[7] == serial_port_enable_q && reg_rdata[4] == continuous_receive_enable_q)
    else $error("control readback wrong");
  AST_OVERRUN_ERROR_FLAG_CLR:
    assert property (s_ctrl_rd ##0 (!continuous_receive_enable_q && !$past(continuous_receive_enable_q)) |=> !reg_rdata[1])
    else $error("overrun set while receive disabled");
  AST_SERIAL_PORT_ENABLE_CLR:
    assert property (s_ctrl_rd ##0 (!serial_port_enable_q && !$past(serial_port_enable_q)) |=> reg_rdata[2:1] == 2'b00)
    else $error("error flags set while port disabled");
  AST_PEND_RB:
    assert property (s_mode_rd |=>
      reg_rdata[7] == $past(receive_pending_flag) && reg_rdata[0] == sync_q)
    else $error("pending readback wrong");
endmodule
bind urx_receiver urx_receiver_checker i_chk
(
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .baud_tick16(baud_tick16),
  .tx_serial_data(tx_serial_data), .tx_pin_out(tx_pin_out), .tx_pin_oe_n(tx_pin_oe_n),
  .rx_pin_oe_n(rx_pin_oe_n), .receive_pending_flag(receive_pending_flag), .rx_irq(rx_irq)
);
`default_nettype wire

// ### bench/urx_tx_model.sv
// remote serial transmitter driving the receive line
`timescale 1ns/10ps
`default_nettype none
module urx_tx_model
(
  input  wire logic clock,
  input  wire logic baud_tick16,
  output logic      line
);
  initial line = 1'b1;
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clock);
      for (int k = 0; k < 16 && !baud_tick16; k++)
        @(posedge clock);
    end
  endtask
  // start bit, data, stop level, one idle bit
  task automatic send(input logic [8:0] d, input int nb, input logic stp);
    @(posedge clock);
    line <= 1'b0;
    ticks(16);
    for (int i = 0; i < nb; i++)
    begin
      line <= d[i];
      ticks(16);
    end
    line <= stp;
    ticks(16);
    line <= 1'b1;
    ticks(16);
  endtask
  // low pulse shorter than half a bit
  task automatic glitch;
    @(posedge clock);
    line <= 1'b0;
    ticks(4);
    line <= 1'b1;
    ticks(16);
  endtask
endmodule
`default_nettype wire

// ### bench/urx_receiver_bench.sv
// self-checking bench of the asynchronous receiver
`timescale 1ns/10ps
`default_nettype none
module urx_receiver_bench;
  logic       clock;
  logic       sys_rst;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       baud_tick16;
  logic [1:0] tick_cnt;
  logic       far_line;
  logic       rx_pin_in;
  logic       rx_pin_out;
  logic       rx_pin_oe_n;
  logic       tx_serial_data;
  logic       tx_pin_out;
  logic       tx_pin_oe_n;
  logic       receive_pending_flag;
  logic       rx_irq;
  int         miscompares;
  int         samples_checked;
  assign rx_pin_in = rx_pin_oe_n ? far_line : rx_pin_out;
  urx_receiver i_dut
  (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .baud_tick16(baud_tick16),
    .rx_pin_in(rx_pin_in), .rx_pin_out(rx_pin_out), .rx_pin_oe_n(rx_pin_oe_n),
    .tx_serial_data(tx_serial_data), .tx_pin_out(tx_pin_out), .tx_pin_oe_n(tx_pin_oe_n),
    .receive_pending_flag(receive_pending_flag), .rx_irq(rx_irq)
  );
  urx_tx_model i_tx (.clock(clock), .baud_tick16(baud_tick16), .line(far_line));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // oversampling tick every fourth clock
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      tick_cnt       <= 2'h0;
      baud_tick16    <= 1'b0;
      tx_serial_data <= 1'b0;
    end
    else
    begin
      tick_cnt       <= tick_cnt + 2'h1;
      baud_tick16    <= (tick_cnt == 2'h3);
      tx_serial_data <= ~tx_serial_data;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic flags(input logic p, input logic q);
    @(posedge clock);
    #1;
    chk({6'h00, receive_pending_flag, rx_irq}, {6'h00, p, q});
  endtask
  // pin outputs: tx enable, rx enable, tx value, rx value
  task automatic pins(input logic [3:0] e, input logic routed);
    @(posedge clock);
    #1;
    chk({4'h0, tx_pin_oe_n, rx_pin_oe_n, tx_pin_out, rx_pin_out},
        {4'h0, e[3:2], routed ? tx_serial_data : e[1], e[0]});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (50000) @(posedge clock);
    miscompares++;
    results;
  end
  initial
  begin
    sys_rst = 1'b1;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rd(2'h0, 8'h00);
    rd(2'h3, 8'h0c);
    pins(4'hc, 1'b0);
    wr(2'h3, 8'h03);
    pins(4'h3, 1'b0);
    $display("test done: reset");
    wr(2'h0, 8'h90);
    pins(4'h5, 1'b1);
    wr(2'h2, 8'h38);
    i_tx.glitch();
    flags(1'b0, 1'b0);
    i_tx.send(9'h03c, 8, 1'b0);
    flags(1'b1, 1'b1);
    i_tx.send(9'h0a5, 8, 1'b1);
    wr(2'h0, 8'h96);
    rd(2'h0, 8'h94);
    rd(2'h1, 8'h3c);
    rd(2'h0, 8'h90);
    rd(2'h1, 8'ha5);
    flags(1'b0, 1'b0);
    $display("test done: framing");
    i_tx.send(9'h011, 8, 1'b1);
    i_tx.send(9'h022, 8, 1'b1);
    i_tx.send(9'h033, 8, 1'b1);
    rd(2'h0, 8'h92);
    i_tx.send(9'h044, 8, 1'b1);
    rd(2'h1, 8'h11);
    wr(2'h0, 8'h80);
    flags(1'b0, 1'b0);
    rd(2'h0, 8'h80);
    rd(2'h1, 8'h22);
    wr(2'h0, 8'h90);
    flags(1'b0, 1'b0);
    i_tx.send(9'h055, 8, 1'b1);
    wr(2'h2, 8'h18);
    flags(1'b1, 1'b0);
    wr(2'h2, 8'hb8);
    rd(2'h2, 8'hb8);
    rd(2'h1, 8'h55);
    $display("test done: overrun and irq");
    wr(2'h0, 8'hd0);
    i_tx.send(9'h1a5, 9, 1'b1);
    rd(2'h0, 8'hd1);
    rd(2'h1, 8'ha5);
    wr(2'h0, 8'hd8);
    i_tx.send(9'h055, 9, 1'b1);
    i_tx.send(9'h1c3, 9, 1'b1);
    rd(2'h0, 8'hd9);
    rd(2'h1, 8'hc3);
    flags(1'b0, 1'b0);
    $display("test done: nine bit");
    wr(2'h2, 8'h39);
    i_tx.send(9'h0a5, 8, 1'b1);
    wr(2'h2, 8'h38);
    flags(1'b0, 1'b0);
    wr(2'h0, 8'h90);
    i_tx.send(9'h03c, 8, 1'b0);
    rd(2'h0, 8'h94);
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h00);
    wr(2'h0, 8'h90);
    flags(1'b0, 1'b0);
    $display("test done: enables");
    results;
  end
endmodule
`default_nettype wire
